// ---- src/hst_regs.svh ----
// Register offsets, field positions, reset values and timing counts.
`ifndef HST_REGS_SVH
`define HST_REGS_SVH

// Byte offsets of the registers on the bus.
`define HST_OFS_CTRL     8'h00
`define HST_OFS_TIMEOUT  8'h04
`define HST_OFS_STATUS   8'h08
`define HST_OFS_DWELL    8'h0C
`define HST_OFS_BINSEL   8'h10
`define HST_OFS_HIT      8'h14
`define HST_OFS_PORT     8'h18
`define HST_OFS_LIVE     8'h1C

// Field positions.
`define HST_CTRL_EN      0
`define HST_CTRL_ODD     1
`define HST_STAT_SAVES   16

// Reset values.
`define HST_RST_TIMEOUT  16'h0708
`define HST_RST_ODD      1'b0

// Timing: one timer step is one second at a 25 MHz clock.
`define HST_TICK_S       1
`define HST_CLK_HZ       25000000

// Dwell level at which the histogram is saved and restarted.
`define HST_DWELL_LIMIT  32'hFFFF_FF00

`endif

// ---- src/hst_pkg.sv ----
// Types shared by the histogram engine files.
package hst_pkg;

   // Measurement state as seen by software.
   typedef enum logic [1:0] {
      MS_INACTIVE,
      MS_BUSY,
      MS_READY
   } hst_meas_t;

   // Engine sequencer states.
   typedef enum logic [1:0] {
      EN_IDLE,
      EN_CLEAR,
      EN_ADD
   } hst_eng_t;

endpackage : hst_pkg

// ---- src/hst_mem.sv ----
// Counter memory with one write port and two registered read ports.
`timescale 1ns/1ps
module hst_mem #(
   parameter int AW = 9,
   parameter int DW = 32
) (
   // Clock.
   input  wire logic          clock,
   // Write port.
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   // Read port A, used by the engine.
   input  wire logic [AW-1:0] ra_addr,
   output logic      [DW-1:0] ra_data,
   // Read port B, used by the bus.
   input  wire logic [AW-1:0] rb_addr,
   output logic      [DW-1:0] rb_data
);

   // The array carries no reset; the engine clears a bank before use.
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Write port.
   always_ff @(posedge clock)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   // Both read ports return data one cycle after the address.
   always_ff @(posedge clock)
   begin
      ra_data <= mem[ra_addr];
      rb_data <= mem[rb_addr];
   end

endmodule : hst_mem

// ---- src/hst_top.sv ----
// Wideband sample histogram engine with an AHB-Lite register slave.
// How it works
// R1 - Enable starts histogram of wideband samples.
// R2 - Two-sided, 256 bins from top eight bits.
// R3 - Each bin has 32-bit hit counter.
// R4 - One shared 32-bit dwell counter for bins.
// R5 - Ten million samples dwell within thirty seconds.
// R6 - Accumulate until restart, disable or timeout.
// R7 - Near dwell overflow save, clear, continue.
// R8 - Enable only when idle; enabling sets busy.
// R9 - Disable stops and produces result.
// R10 - Enable reads true only while collecting.
// R11 - Disable then enable restarts fresh accumulation.
// R12 - Seconds timeout timer, default 1800.
// R13 - Timeout clears enable, saves, result available.
// R14 - Zero timeout means no time limit.
// R15 - Timeout rewrite while enabled reloads timer.
// R16 - Timeout write never starts; reads last written.
// R17 - Result available only when counts complete.
// R18 - Odd symmetry leaves bin zero unused.
// R19 - One-second tick decrements 16-bit timeout.
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "hst_regs.svh"
module hst_top
   import hst_pkg::*;
#(
   parameter int ADC_W       = 12,
   parameter int CLK_PER_SEC = `HST_CLK_HZ * `HST_TICK_S,
   parameter int PORT_INDEX  = 0
) (
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst,
   // AHB-Lite slave.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // Wideband converter sample stream.
   input  wire logic             sample_valid,
   input  wire logic [ADC_W-1:0] sample_data,
   // Status pins.
   output logic             capture_active,
   output logic      [1:0]  measurement_state
);

   // Fewer than nine sample bits cannot feed the bin mapping; the tick divider needs a count of at least one.
   if (ADC_W < 9 || ADC_W > 32 || CLK_PER_SEC < 1)
   begin : bad_param
      $error("hst_top: unsupported parameter value");
   end

   // Bus data phase bookkeeping.
   logic        dp_wr_reg;         // Write data phase pending.
   logic [7:0]  dp_addr_reg;       // Register offset of the transfer.
   // Software visible control.
   logic        enable_reg;        // Collecting histogram data.
   logic        odd_reg;           // Odd symmetry selected.
   logic [15:0] timeout_reg;       // Timeout in seconds.
   logic [7:0]  bin_sel_reg;       // Bin chosen for readout.
   // Timer.
   logic [31:0] tick_cnt_reg;      // Clock cycles within a second.
   logic        tick_reg;          // One-second pulse.
   logic [15:0] timer_reg;         // Seconds left.
   // Requests waiting for the engine.
   logic        start_pend_reg;
   logic        stop_pend_reg;
   // Engine.
   hst_eng_t    eng_reg;
   hst_meas_t   meas_reg;
   logic        res_bank_reg;      // Bank holding the saved result.
   logic [7:0]  clr_idx_reg;       // Clear walk index.
   logic [7:0]  cur_bin_reg;       // Bin being incremented.
   logic [31:0] dwell_reg;         // Live shared dwell count.
   logic [31:0] saved_dwell_reg;   // Dwell of the saved result.
   logic [15:0] saves_reg;         // Number of saved results.
   // Memory ports.
   logic        mem_we;
   logic [8:0]  mem_waddr;
   logic [31:0] mem_wdata;
   logic [8:0]  mem_raddr;
   logic [31:0] mem_rdata;
   logic [31:0] hit_rdata;
   // Decoded strobes.
   logic        ap_ok;
   logic        wr_ctrl;
   logic        wr_tmo;
   logic        start_req;
   logic        stop_req;
   logic        expire;
   logic        take_start;
   logic        take_stop;
   logic        take_save;
   logic        take_sample;
   logic [7:0]  sample_bin;

   // Samples are counted into the bank that is not holding the result.
   hst_mem #(
      .AW (9),
      .DW (32)
   ) u_mem (
      .clock   (clock),
      .we      (mem_we),
      .waddr   (mem_waddr),
      .wdata   (mem_wdata),
      .ra_addr (mem_raddr),
      .ra_data (mem_rdata),
      .rb_addr ({res_bank_reg, bin_sel_reg}),
      .rb_data (hit_rdata)
   );

   // Sample to bin mapping over the top nine bits of the sample.
   always_comb
   begin
      logic signed [8:0] s9;
      logic signed [9:0] rnd;
      logic signed [8:0] r9;
      s9  = sample_data[ADC_W-1 -: 9];
      rnd = 10'sh000;
      r9  = 9'sh000;
      if (odd_reg)
      begin
         // Centres on integers; bin zero stays unused.  R18
         rnd = {s9[8], s9} + 10'sh001;
         r9  = rnd[9:1];
         if (r9 < -9'sd127)
         begin
            r9 = -9'sd127;
         end
         else if (r9 > 9'sd127)
         begin
            r9 = 9'sd127;
         end
         sample_bin = r9[7:0] ^ 8'h80;  // R2
      end
      else
      begin
         // Centres half a step off zero, all 256 bins used.  R2
         sample_bin = {~s9[8], s9[7:1]};
      end
   end

   // Address phase acceptance and write strobes in the data phase.
   assign ap_ok   = hsel && hready && htrans[1];
   assign wr_ctrl = dp_wr_reg && (dp_addr_reg == `HST_OFS_CTRL);
   assign wr_tmo  = dp_wr_reg && (dp_addr_reg == `HST_OFS_TIMEOUT);

   // A start is honoured only when no capture runs or one is being
   // stopped, so a disable followed by an enable restarts.
   assign start_req = wr_ctrl && hwdata[`HST_CTRL_EN]
                      && (meas_reg != MS_BUSY || stop_pend_reg); // R8 R11
   assign stop_req  = wr_ctrl && !hwdata[`HST_CTRL_EN]
                      && enable_reg;                             // R9

   // Timer runs out when the last second elapses; zero never expires.
   assign expire = enable_reg && tick_reg && (timer_reg == 16'h0001)
                   && !wr_tmo;                                  // R13 R14

   // Engine decisions, all taken between samples in the idle state.
   assign take_stop   = (eng_reg == EN_IDLE) && stop_pend_reg;
   assign take_start  = (eng_reg == EN_IDLE) && !stop_pend_reg
                        && start_pend_reg;
   assign take_save   = (eng_reg == EN_IDLE) && !stop_pend_reg
                        && !start_pend_reg && enable_reg
                        && (dwell_reg >= `HST_DWELL_LIMIT);      // R7
   assign take_sample = (eng_reg == EN_IDLE) && !stop_pend_reg
                        && !start_pend_reg && enable_reg
                        && !take_save && sample_valid;           // R1 R6

   // Memory port steering: read on take, increment one cycle later.
   always_comb
   begin
      mem_raddr = {~res_bank_reg, sample_bin};
      mem_we    = 1'b0;
      mem_waddr = {~res_bank_reg, clr_idx_reg};
      mem_wdata = 32'h0000_0000;
      case (eng_reg)
         EN_CLEAR:
         begin
            mem_we = 1'b1;
         end
         EN_ADD:
         begin
            // Read-modify-write of one hit counter.  R3
            mem_we    = 1'b1;
            mem_waddr = {~res_bank_reg, cur_bin_reg};
            mem_wdata = mem_rdata + 32'h0000_0001;
         end
         default:
         begin
            mem_we = 1'b0;
         end
      endcase
   end

   // Bus data phase tracking.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         dp_wr_reg   <= 1'b0;
         dp_addr_reg <= 8'h00;
      end
      else
      begin
         dp_wr_reg <= ap_ok && hwrite;
         if (ap_ok)
         begin
            dp_addr_reg <= haddr[7:0];
         end
      end
   end

   // The slave never waits and always answers OKAY.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Read data is captured in the address phase; unmapped reads zero.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         hrdata <= 32'h0000_0000;
      end
      else if (ap_ok && !hwrite)
      begin
         case (haddr[7:0])
            `HST_OFS_CTRL:
               hrdata <= {30'h0, odd_reg, enable_reg};         // R10
            `HST_OFS_TIMEOUT:
               hrdata <= {16'h0000, timeout_reg};              // R16
            `HST_OFS_STATUS:
               hrdata <= {saves_reg, 14'h0, meas_reg};         // R17
            `HST_OFS_DWELL:
               hrdata <= saved_dwell_reg;                      // R4
            `HST_OFS_BINSEL:
               hrdata <= {24'h0, bin_sel_reg};
            `HST_OFS_HIT:
               // Bin zero is unused in odd symmetry.  R18
               hrdata <= (odd_reg && bin_sel_reg == 8'h00)
                         ? 32'h0000_0000 : hit_rdata;
            `HST_OFS_PORT:
               hrdata <= 32'(PORT_INDEX);
            `HST_OFS_LIVE:
               hrdata <= dwell_reg;
            default:
               hrdata <= 32'h0000_0000;
         endcase
      end
      else
      begin
         hrdata <= 32'h0000_0000;
      end
   end

   // Software settings; symmetry is frozen while a capture runs
   // because a change would mix two bin layouts in one result.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         odd_reg     <= `HST_RST_ODD;
         timeout_reg <= `HST_RST_TIMEOUT;
         bin_sel_reg <= 8'h00;
      end
      else
      begin
         if (wr_ctrl && meas_reg != MS_BUSY)
         begin
            odd_reg <= hwdata[`HST_CTRL_ODD];
         end
         if (wr_tmo)
         begin
            timeout_reg <= hwdata[15:0];                      // R12 R16
         end
         if (dp_wr_reg && dp_addr_reg == `HST_OFS_BINSEL)
         begin
            bin_sel_reg <= hwdata[7:0];
         end
      end
   end

   // Pending requests; a new request wins over its own clear.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         start_pend_reg <= 1'b0;
         stop_pend_reg  <= 1'b0;
      end
      else
      begin
         if (start_req)
         begin
            start_pend_reg <= 1'b1;                           // R8
         end
         else if (take_start)
         begin
            start_pend_reg <= 1'b0;
         end
         if (stop_req || expire)
         begin
            stop_pend_reg <= 1'b1;                            // R9 R13
         end
         else if (take_stop)
         begin
            stop_pend_reg <= 1'b0;
         end
      end
   end

   // One-second tick divider, restarted with the timer.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         tick_cnt_reg <= 32'h0000_0000;
         tick_reg     <= 1'b0;
      end
      else if (!enable_reg || take_start || wr_tmo)
      begin
         tick_cnt_reg <= 32'h0000_0000;
         tick_reg     <= 1'b0;
      end
      else if (tick_cnt_reg == 32'(CLK_PER_SEC - 1))
      begin
         tick_cnt_reg <= 32'h0000_0000;
         tick_reg     <= 1'b1;                                // R19
      end
      else
      begin
         tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
         tick_reg     <= 1'b0;
      end
   end

   // Seconds timer; a zero load leaves it idle for an open capture.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         timer_reg <= 16'h0000;
      end
      else if (wr_tmo && enable_reg)
      begin
         timer_reg <= hwdata[15:0];                           // R15
      end
      else if (take_start)
      begin
         timer_reg <= timeout_reg;                            // R12
      end
      else if (tick_reg && timer_reg != 16'h0000)
      begin
         timer_reg <= timer_reg - 16'h0001;                   // R19 R14
      end
   end

   // Engine sequencer, capture state and result banks.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         eng_reg         <= EN_IDLE;
         meas_reg        <= MS_INACTIVE;
         enable_reg      <= 1'b0;
         res_bank_reg    <= 1'b0;
         clr_idx_reg     <= 8'h00;
         cur_bin_reg     <= 8'h00;
         dwell_reg       <= 32'h0000_0000;
         saved_dwell_reg <= 32'h0000_0000;
         saves_reg       <= 16'h0000;
      end
      else
      begin
         case (eng_reg)
            EN_IDLE:
            begin
               if (take_stop)
               begin
                  // Hand the live bank over as the result.  R9 R13
                  enable_reg      <= 1'b0;
                  meas_reg        <= MS_READY;                // R17
                  res_bank_reg    <= ~res_bank_reg;
                  saved_dwell_reg <= dwell_reg;
                  saves_reg       <= saves_reg + 16'h0001;
               end
               else if (take_start)
               begin
                  // Fresh accumulation into a cleared bank.  R11
                  enable_reg  <= 1'b1;                        // R1
                  meas_reg    <= MS_BUSY;                     // R8
                  dwell_reg   <= 32'h0000_0000;
                  clr_idx_reg <= 8'h00;
                  eng_reg     <= EN_CLEAR;
               end
               else if (take_save)
               begin
                  // Keep a complete result, then carry on.  R7
                  res_bank_reg    <= ~res_bank_reg;
                  saved_dwell_reg <= dwell_reg;
                  saves_reg       <= saves_reg + 16'h0001;
                  dwell_reg       <= 32'h0000_0000;
                  clr_idx_reg     <= 8'h00;
                  eng_reg         <= EN_CLEAR;
               end
               else if (take_sample)
               begin
                  cur_bin_reg <= sample_bin;
                  eng_reg     <= EN_ADD;
               end
            end
            EN_CLEAR:
            begin
               // Samples are not counted during the 256-cycle clear.
               clr_idx_reg <= clr_idx_reg + 8'h01;
               if (clr_idx_reg == 8'hFF)
               begin
                  eng_reg <= EN_IDLE;
               end
            end
            EN_ADD:
            begin
               // Every counted sample adds to the shared dwell.  R4 R5
               dwell_reg <= dwell_reg + 32'h0000_0001;
               eng_reg   <= EN_IDLE;
            end
            default:
            begin
               eng_reg <= EN_IDLE;
            end
         endcase
      end
   end

   // Status pins mirror the capture state.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         capture_active    <= 1'b0;
         measurement_state <= 2'h0;
      end
      else
      begin
         capture_active    <= enable_reg;                     // R10
         measurement_state <= meas_reg;
      end
   end

endmodule : hst_top

// ---- test/hst_adc_model.sv ----
// Behavioural wideband converter that feeds samples to the engine.
`timescale 1ns/1ps
module hst_adc_model #(
   parameter int W = 12
) (
   // Clock and reset.
   input  wire logic         clock,
   input  wire logic         rst,
   // Control from the bench.
   input  wire logic         go,
   input  wire logic [W-1:0] value,
   // Sample stream toward the engine.
   output logic              sample_valid,
   output logic      [W-1:0] sample_data
);
   // One sample every other cycle, the fastest rate the engine counts.
   // Between samples the data bits flip, so stale data never looks valid.
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sample_valid <= 1'b0;
         sample_data  <= '0;
      end
      else if (go && !sample_valid)
      begin
         sample_valid <= 1'b1;
         sample_data  <= value;
      end
      else
      begin
         sample_valid <= 1'b0;
         sample_data  <= ~sample_data;
      end
   end
endmodule : hst_adc_model

// ---- test/hst_top_checker.sv ----
// Port-level assertions for the histogram engine.
`timescale 1ns/1ps
`include "hst_regs.svh"
module hst_top_checker (
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst,
   // Bus signals.
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic        hreadyout,
   input  wire logic        hresp,
   input  wire logic [31:0] hrdata,
   // Status pins.
   input  wire logic        capture_active,
   input  wire logic [1:0]  measurement_state
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // A transfer is taken when selected, ready and not idle.
   logic take;
   assign take = hsel && hready && htrans[1];

   // Enable written as one while no capture is busy.
   sequence en_wr_s;
      (take && hwrite && haddr[7:0] == `HST_OFS_CTRL &&
       measurement_state != 2'h1) ##1 hwdata[0];
   endsequence
   // Timeout written while nothing is collecting.
   sequence tmo_wr_s;
      take && hwrite && haddr[7:0] == `HST_OFS_TIMEOUT && !capture_active;
   endsequence

   resp_okay_a: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   ready_high_a: assert property (!$past(rst) |-> hreadyout)
      else $error("ready low outside reset");
   rdata_idle_a: assert property (!$past(take && !hwrite) |-> hrdata == 32'h0)
      else $error("read data outside a read data phase");
   state_legal_a: assert property (measurement_state != 2'h3)
      else $error("illegal measurement state");
   start_busy_a: assert property (en_wr_s |-> ##[1:8] capture_active)
      else $error("enable write did not start capture");
   active_busy_a: assert property ($rose(capture_active) |->
      measurement_state == 2'h1)
      else $error("capture without busy state");
   stop_ready_a: assert property ($fell(capture_active) |->
      measurement_state == 2'h2)
      else $error("stop without result available");
   ready_keep_a: assert property (measurement_state == 2'h2 |=>
      measurement_state != 2'h0)
      else $error("result lost");
   tmo_nostart_a: assert property (tmo_wr_s |-> !capture_active [*4])
      else $error("timeout write started capture");
endmodule : hst_top_checker

// ---- test/test_upstream_sample_histogram.sv ----
// Self-checking bench for the wideband sample histogram engine.
`timescale 1ns/1ps
`include "hst_regs.svh"
module test_upstream_sample_histogram;
   import hst_pkg::*;
   localparam int CPS  = 100; // Timer second shortened to keep runs brief.
   localparam int PIDX = 5;   // Port index strapped on the engine.
   logic        clock, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic        sample_valid, capture_active, adc_go;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, measurement_state;
   logic [2:0]  hsize;
   logic [11:0] sample_data, adc_value;
   int          errors, comparisons, saves, n;

   // The single slave drives the bus ready.
   assign hready = hreadyout;
   always #20 clock = ~clock;

   hst_top #(.ADC_W(12), .CLK_PER_SEC(CPS), .PORT_INDEX(PIDX)) hst_top_inst (
      .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .sample_valid(sample_valid),
      .sample_data(sample_data), .capture_active(capture_active),
      .measurement_state(measurement_state));
   hst_adc_model #(.W(12)) hst_adc_model_inst (
      .clock(clock), .rst(rst), .go(adc_go), .value(adc_value),
      .sample_valid(sample_valid), .sample_data(sample_data));

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   // Compares one value and reports a mismatch at once.
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Waits for ready at a rising edge; a hang ends the run.
   task automatic wait_ready();
      int k;
      k = 0;
      do
      begin
         @(posedge clock);
         k++;
      end
      while (hready !== 1'b1 && k < 100);
      if (hready !== 1'b1)
      begin
         check("bus ready", 1, 0);
         print_verdict();
      end
   endtask : wait_ready

   // One single word transfer: address phase, then data phase.
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clock);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h0, a};
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      hsel <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      bus(1'b1, a, d, v);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input string what);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      check(what, e, v);
   endtask : rd

   // Selects a bin of the saved result and reads its hit count.
   task automatic hit(input logic [7:0] b, input logic [31:0] e);
      wr(`HST_OFS_BINSEL, {24'h0, b});
      rd(`HST_OFS_HIT, e, "hit count");
   endtask : hit

   // Waits, bounded, for the measurement state to reach a value.
   task automatic wait_state(input logic [1:0] e, input int bound);
      n = 0;
      while (measurement_state !== e && n < bound)
      begin
         @(posedge clock);
         n++;
      end
      if (measurement_state !== e)
      begin
         check("state wait", e, measurement_state);
         print_verdict();
      end
   endtask : wait_state

   // Starts a capture and lets the 256-cycle bank clear finish.
   task automatic start(input logic [31:0] ctrl);
      wr(`HST_OFS_CTRL, ctrl);
      wait_state(2'h1, 20);
      repeat (300) @(posedge clock);
   endtask : start

   // Sends samples of one value, one every other cycle.
   task automatic send(input logic [11:0] v, input int cnt);
      @(posedge clock);
      adc_value <= v;
      adc_go    <= 1'b1;
      repeat (2 * cnt) @(posedge clock);
      adc_go <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : send

   // Stops the capture and checks the saved dwell and save count.
   task automatic stop(input logic [31:0] dwell);
      logic [31:0] v;
      wr(`HST_OFS_CTRL, 32'h0);
      wait_state(2'h2, 20);
      saves++;
      // Only the enable bit is judged; odd symmetry may still be set.
      bus(1'b0, `HST_OFS_CTRL, 32'h0, v);
      check("enable after stop", 32'h0, {31'h0, v[`HST_CTRL_EN]});
      rd(`HST_OFS_DWELL, dwell, "saved dwell");
      bus(1'b0, `HST_OFS_STATUS, 32'h0, v);
      check("saves", saves, {16'h0, v[31:16]});
   endtask : stop

   task automatic sc_reset();
      rd(`HST_OFS_TIMEOUT, 32'h708, "timeout default");
      rd(`HST_OFS_CTRL, 32'h0, "enable after reset");
      rd(`HST_OFS_STATUS, 32'h0, "status after reset");
      rd(8'h20, 32'h0, "unmapped read");
      rd(`HST_OFS_PORT, PIDX, "port index");
   endtask : sc_reset

   // Even bins at both ends and the middle, with no time limit.
   task automatic sc_even();
      wr(`HST_OFS_TIMEOUT, 32'h0);
      rd(`HST_OFS_TIMEOUT, 32'h0, "timeout readback");
      rd(`HST_OFS_CTRL, 32'h0, "enable after timeout write");
      start(32'h1);
      rd(`HST_OFS_CTRL, 32'h1, "enable while collecting");
      send(12'h7F0, 5);
      send(12'h800, 3);
      rd(`HST_OFS_LIVE, 32'h8, "live dwell");
      check("state no limit", 2'h1, measurement_state);
      stop(32'h8);
      hit(8'hFF, 32'h5);
      hit(8'h00, 32'h3);
      hit(8'h80, 32'h0);
   endtask : sc_even

   // Odd symmetry: bin zero stays empty, the negative extreme clamps to bin one.
   task automatic sc_odd();
      wr(`HST_OFS_CTRL, 32'h2);
      start(32'h3);
      send(12'h800, 4);
      send(12'h000, 2);
      stop(32'h6);
      hit(8'h01, 32'h4);
      hit(8'h80, 32'h2);
      hit(8'h00, 32'h0);
   endtask : sc_odd

   // Disable then enable again begins a fresh accumulation.
   task automatic sc_restart();
      start(32'h1);
      send(12'h000, 3);
      stop(32'h3);
      start(32'h1);
      send(12'h000, 2);
      stop(32'h2);
      hit(8'h80, 32'h2);
   endtask : sc_restart

   // Expiry after three timer seconds, then a rewrite that reloads.
   task automatic sc_timeout();
      wr(`HST_OFS_TIMEOUT, 32'h3);
      wr(`HST_OFS_CTRL, 32'h1);
      wait_state(2'h1, 20);
      wait_state(2'h2, 4 * CPS);
      check("expiry window", 1, n >= 3 * CPS && n <= 3 * CPS + 8);
      saves++;
      rd(`HST_OFS_CTRL, 32'h0, "enable after expiry");
      rd(`HST_OFS_TIMEOUT, 32'h3, "timeout kept");
      wr(`HST_OFS_CTRL, 32'h1);
      wait_state(2'h1, 20);
      repeat (2 * CPS) @(posedge clock);
      wr(`HST_OFS_TIMEOUT, 32'h3);
      check("still busy", 2'h1, measurement_state);
      wait_state(2'h2, 4 * CPS);
      check("reload window", 1, n >= 3 * CPS && n <= 3 * CPS + 8);
   endtask : sc_timeout

   initial
   begin
      clock = 1'b0;
      rst = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      adc_go = 1'b0;
      adc_value = 12'h0;
      errors = 0;
      comparisons = 0;
      saves = 0;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      sc_reset();
      sc_even();
      sc_odd();
      sc_restart();
      sc_timeout();
      print_verdict();
   end
endmodule : test_upstream_sample_histogram

bind hst_top hst_top_checker hst_top_checker_inst (
   .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .capture_active(capture_active),
   .measurement_state(measurement_state));
